// ---- src/crr_ctrl.sv ----
/*
 Charge-rationing controller: accumulates delivered charge in the Active state,
 runs the threshold actions, the rationing-reset sequence and behaviour changes
 after threshold. Assumes an outside power-state machine that obeys the force
 outputs and a register master that follows the one-cycle strobe protocol.
*/
// Chosen here: the plain strobed port and the placing of the registers.
`timescale 1ns/1ps
module crr_ctrl #(
   parameter int ACCW = crr_pkg::ACC_W
) (
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic [7:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   input wire logic mode_pin_a,
   input wire logic mode_pin_b,
   input wire logic emulation_allow_pin,
   input wire logic bypass_select_pin,
   input wire logic port_switch_enable_pin,
   input wire logic power_active,
   input wire logic charge_tick,
   input wire logic [7:0] charge_amount,
   input wire logic removal_evt,
   input wire logic attach_evt,
   output logic alert_n,
   output logic emul_remove,
   output logic switch_open,
   output logic sleep_force,
   output logic power_reselect,
   output logic emul_restart,
   output logic irq
);
   import crr_pkg::*;

   crr_state_e st_ff, nxt_st;
   crr_beh_e beh_ff, act_beh_ff, nxt_act_beh;
   logic en_ff, rst_pend_ff, flag_ff, removed_ff;
   logic [ACCW-1:0] accum_ff, limit_ff, nxt_accum;
   logic [PIN_W-1:0] cap_ff;
   logic [IRQ_W-1:0] irq_stat_ff, irq_mask_ff;
   logic alert_n_ff, emul_remove_ff, switch_open_ff, sleep_ff;
   logic reselect_ff, restart_ff, irq_ff;
   logic [31:0] rdata_ff;

   // decode
   wire wr_ctrl = reg_wr && (reg_addr == OFS_CTRL);
   wire wr_limit = reg_wr && (reg_addr == OFS_LIMIT);
   wire wr_istat = reg_wr && (reg_addr == OFS_IRQ_STAT);
   wire wr_imask = reg_wr && (reg_addr == OFS_IRQ_MASK);
   wire rst_req = wr_ctrl && reg_wdata[CTRL_RST_BIT];
   wire rst_any = rst_req || rst_pend_ff;
   wire [PIN_W-1:0] pins = {mode_pin_a, mode_pin_b, emulation_allow_pin,
                            bypass_select_pin, port_switch_enable_pin};
   wire pins_changed = (pins != cap_ff);
   wire [ACCW:0] acc_sum = {1'b0, accum_ff} + {{(ACCW-7){1'b0}}, charge_amount};
   wire [ACCW-1:0] acc_sat = acc_sum[ACCW] ? '1 : acc_sum[ACCW-1:0];
   wire accumulate = en_ff && power_active && charge_tick && (st_ff == S_NORM);
   wire hit = en_ff && power_active && (st_ff == S_NORM) && (accum_ff >= limit_ff);
   wire beh_is_rep = (act_beh_ff == BEH_REPORT) || (act_beh_ff == BEH_REPORT_DISC);
   wire beh_chg = (beh_ff != act_beh_ff);
   // the sleep chain runs open-first at threshold but remove-first when leaving ignore,
   // so each step looks at which forced output is already in place
   wire ds_open_done = (act_beh_ff == BEH_DISC_SLEEP) && switch_open_ff;
   wire ds_rm_done = (act_beh_ff == BEH_DISC_SLEEP) && emul_remove_ff;
   wire reattach = removed_ff && attach_evt && (st_ff == S_NORM) && en_ff && power_active;
   wire restart_now = ((st_ff == S_R_CHECK) && pins_changed && emulation_allow_pin)
                      || reattach;
   wire [IRQ_W-1:0] irq_set = {restart_now, (st_ff == S_R_CLEAR), hit};

   // only the reset state or accumulation moves the accumulator
   assign nxt_accum = (st_ff == S_R_CLEAR) ? '0 : (accumulate ? acc_sat : accum_ff);

   always_comb begin
      nxt_st = st_ff;
      nxt_act_beh = act_beh_ff;
      unique case (st_ff)
         S_NORM: begin
            nxt_act_beh = beh_ff;
            if (rst_any) begin
               nxt_st = S_R_CLEAR;
            end else if (hit) begin
               unique case (beh_ff)
                  BEH_REPORT, BEH_REPORT_DISC: nxt_st = S_A_ALERT;
                  BEH_DISC_SLEEP: nxt_st = S_A_OPEN;
                  BEH_IGNORE: nxt_st = S_HELD;
               endcase
            end
         end
         S_A_ALERT: nxt_st = (act_beh_ff == BEH_REPORT_DISC) ? S_A_REMOVE : S_HELD;
         S_A_REMOVE: nxt_st = ds_open_done ? S_A_SLEEP : S_A_OPEN;
         S_A_OPEN: begin
            if (act_beh_ff != BEH_DISC_SLEEP) begin
               nxt_st = S_HELD;
            end else if (ds_rm_done) begin
               nxt_st = S_A_SLEEP;
            end else begin
               nxt_st = S_A_REMOVE;
            end
         end
         S_A_SLEEP: nxt_st = S_HELD;
         S_HELD: begin
            if (rst_any) begin
               nxt_st = S_R_CLEAR;
            end else if (beh_chg) begin
               nxt_act_beh = beh_ff;
               // only leaving ignore starts a fresh action chain; other pairs just adopt
               if (act_beh_ff == BEH_IGNORE) begin
                  unique case (beh_ff)
                     BEH_REPORT, BEH_REPORT_DISC: nxt_st = S_A_ALERT;
                     BEH_DISC_SLEEP: nxt_st = S_A_REMOVE;
                     BEH_IGNORE: nxt_st = S_HELD;
                  endcase
               end
            end
         end
         S_R_CLEAR: nxt_st = S_R_FLAG;
         S_R_FLAG: begin
            if (flag_ff && beh_is_rep) begin
               nxt_st = S_R_RELEASE;
            end else if (flag_ff && (act_beh_ff == BEH_DISC_SLEEP)) begin
               nxt_st = S_R_CHECK;
            end else begin
               nxt_st = S_NORM;
            end
         end
         S_R_RELEASE: nxt_st = (act_beh_ff == BEH_REPORT_DISC) ? S_R_CHECK : S_NORM;
         S_R_CHECK: nxt_st = S_NORM;
      endcase
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         st_ff <= S_NORM;
         act_beh_ff <= BEH_RESET;
         accum_ff <= '0;
         rst_pend_ff <= 1'b0;
      end else begin
         st_ff <= nxt_st;
         act_beh_ff <= nxt_act_beh;
         accum_ff <= nxt_accum;
         rst_pend_ff <= rst_any && !((st_ff == S_NORM) || (st_ff == S_HELD));
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         beh_ff <= BEH_RESET;
         en_ff <= 1'b0;
         limit_ff <= LIMIT_RESET;
         irq_mask_ff <= IRQ_MASK_RESET;
      end else begin
         if (wr_ctrl) begin
            beh_ff <= crr_beh_e'(reg_wdata[CTRL_BEH_LSB +: 2]);
            en_ff <= reg_wdata[CTRL_EN_BIT];
         end
         if (wr_limit) begin
            limit_ff <= reg_wdata[ACCW-1:0];
         end
         if (wr_imask) begin
            irq_mask_ff <= reg_wdata[IRQ_W-1:0];
         end
      end
   end

   // flag, pin capture and re-attach tracking
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         flag_ff <= 1'b0;
         cap_ff <= '0;
         removed_ff <= 1'b0;
      end else begin
         if (hit) begin
            flag_ff <= 1'b1;
            cap_ff <= pins;
         end else if (st_ff == S_R_FLAG) begin
            flag_ff <= 1'b0;
         end
         // events only steer emulation, never the accumulator
         if (removal_evt) begin
            removed_ff <= 1'b1;
         end else if (reattach) begin
            removed_ff <= 1'b0;
         end
      end
   end

   // forced outputs of the threshold actions, plus the reselect and restart pulses
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         alert_n_ff <= 1'b1;
         emul_remove_ff <= 1'b0;
         switch_open_ff <= 1'b0;
         sleep_ff <= 1'b0;
         reselect_ff <= 1'b0;
         restart_ff <= 1'b0;
      end else begin
         if (st_ff == S_A_ALERT) begin
            alert_n_ff <= 1'b0;
         end else if (st_ff == S_R_RELEASE) begin
            alert_n_ff <= 1'b1;
         end
         if (st_ff == S_A_REMOVE) begin
            emul_remove_ff <= 1'b1;
         end else if (st_ff == S_R_FLAG || st_ff == S_R_CHECK) begin
            emul_remove_ff <= emul_remove_ff && (st_ff == S_R_FLAG);
         end
         if (st_ff == S_A_OPEN) begin
            switch_open_ff <= 1'b1;
         end else if (st_ff == S_R_CHECK) begin
            switch_open_ff <= 1'b0;
         end
         if (st_ff == S_A_SLEEP) begin
            sleep_ff <= 1'b1;
         end else if (st_ff == S_R_CHECK) begin
            sleep_ff <= 1'b0;
         end
         reselect_ff <= (st_ff == S_R_CHECK) && pins_changed;
         restart_ff <= restart_now;
      end
   end

   // sticky events, set wins over a write-one clear
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         irq_stat_ff <= '0;
         irq_ff <= 1'b0;
      end else begin
         irq_stat_ff <= irq_set | (irq_stat_ff & ~(wr_istat ? reg_wdata[IRQ_W-1:0] : '0));
         irq_ff <= |((irq_set | irq_stat_ff) & irq_mask_ff);
      end
   end

   wire [31:0] rd_mux =
      (reg_addr == OFS_CTRL) ? {28'h0000000, en_ff, 1'b0, beh_ff} :
      (reg_addr == OFS_STATUS) ? {23'h000000, st_ff, sleep_ff, switch_open_ff,
                                  emul_remove_ff, !alert_n_ff, flag_ff} :
      (reg_addr == OFS_LIMIT) ? {{(32-ACCW){1'b0}}, limit_ff} :
      (reg_addr == OFS_ACCUM) ? {{(32-ACCW){1'b0}}, accum_ff} :
      (reg_addr == OFS_IRQ_STAT) ? {{(32-IRQ_W){1'b0}}, irq_stat_ff} :
      (reg_addr == OFS_IRQ_MASK) ? {{(32-IRQ_W){1'b0}}, irq_mask_ff} : 32'h00000000;

   // read data stands only in the cycle after the strobe
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         rdata_ff <= '0;
      end else begin
         rdata_ff <= reg_rd ? rd_mux : 32'h00000000;
      end
   end

   assign reg_rdata = rdata_ff;
   assign alert_n = alert_n_ff;
   assign emul_remove = emul_remove_ff;
   assign switch_open = switch_open_ff;
   assign sleep_force = sleep_ff;
   assign power_reselect = reselect_ff;
   assign emul_restart = restart_ff;
   assign irq = irq_ff;

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_n);

   sequence seq_ign_to_rd;
      (st_ff == S_HELD) && (act_beh_ff == BEH_IGNORE) && (beh_ff == BEH_REPORT_DISC)
         && !rst_any;
   endsequence
   sequence seq_ign_to_ds;
      (st_ff == S_HELD) && (act_beh_ff == BEH_IGNORE) && (beh_ff == BEH_DISC_SLEEP)
         && !rst_any && alert_n_ff;
   endsequence

   accum_clear_a: assert property ((st_ff == S_R_CLEAR) |=> (accum_ff == '0) ##1 !flag_ff)
      else $error("reset did not clear accumulator and flag");
   alert_keep_a: assert property ((st_ff == S_R_FLAG) && flag_ff && !beh_is_rep
      |=> $stable(alert_n_ff))
      else $error("reset touched alert under ignore or sleep");
   pin_restart_a: assert property ((st_ff == S_R_CHECK) && pins_changed && emulation_allow_pin
      |=> reselect_ff && restart_ff)
      else $error("changed pins did not restart emulation");
   pin_same_a: assert property ((st_ff == S_R_CHECK) && !pins_changed
      |=> !reselect_ff && !switch_open_ff && !sleep_ff)
      else $error("unchanged pins caused a reselect");
   active_only_a: assert property (!power_active && (st_ff != S_R_CLEAR)
      |=> $stable(accum_ff))
      else $error("accumulated outside Active");
   event_keep_a: assert property ((removal_evt || attach_evt) && !charge_tick
      && (st_ff != S_R_CLEAR) |=> $stable(accum_ff))
      else $error("detection event moved accumulator");
   ign_rd_seq_a: assert property (seq_ign_to_rd
      |-> ##2 !alert_n_ff ##1 emul_remove_ff ##1 switch_open_ff)
      else $error("ignore to report-disconnect order wrong");
   ign_ds_seq_a: assert property (seq_ign_to_ds
      |-> ##2 (emul_remove_ff && alert_n_ff) ##1 (switch_open_ff && alert_n_ff)
      ##1 (sleep_ff && alert_n_ff))
      else $error("ignore to sleep order wrong");
   sleep_freeze_a: assert property (sleep_ff && (st_ff == S_HELD) |=> !reselect_ff)
      else $error("pins acted while asleep");
   reset_bound_a: assert property ((st_ff == S_R_CLEAR) |-> ##[1:4] (st_ff == S_NORM))
      else $error("reset sequence too long");
   capture_a: assert property (hit |=> (cap_ff == $past(pins)))
      else $error("pins not captured at threshold");
endmodule

// ---- src/crr_pkg.sv ----
/*
 Constants for the charge-rationing reset and behaviour-change controller:
 register offsets, field positions, reset values, behaviour codes and sequencer states.
 Assumes a 32-bit word register port with byte addresses.
*/
package crr_pkg;
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_STATUS = 8'h04;
   localparam logic [7:0] OFS_LIMIT = 8'h08;
   localparam logic [7:0] OFS_ACCUM = 8'h0C;
   localparam logic [7:0] OFS_IRQ_STAT = 8'h10;
   localparam logic [7:0] OFS_IRQ_MASK = 8'h14;

   localparam int CTRL_BEH_LSB = 0;
   localparam int CTRL_RST_BIT = 2;
   localparam int CTRL_EN_BIT = 3;

   localparam int IRQ_HIT_BIT = 0;
   localparam int IRQ_RESET_BIT = 1;
   localparam int IRQ_RESTART_BIT = 2;
   localparam int IRQ_W = 3;

   localparam int ACC_W = 16;
   localparam int PIN_W = 5;

   typedef enum logic [1:0] {
      BEH_REPORT = 2'h0,
      BEH_REPORT_DISC = 2'h1,
      BEH_DISC_SLEEP = 2'h2,
      BEH_IGNORE = 2'h3
   } crr_beh_e;

   localparam crr_beh_e BEH_RESET = BEH_REPORT_DISC;
   localparam logic [ACC_W-1:0] LIMIT_RESET = 16'h0000;
   localparam logic [IRQ_W-1:0] IRQ_MASK_RESET = 3'h0;

   typedef enum logic [3:0] {
      S_NORM,
      S_A_ALERT,
      S_A_REMOVE,
      S_A_OPEN,
      S_A_SLEEP,
      S_HELD,
      S_R_CLEAR,
      S_R_FLAG,
      S_R_RELEASE,
      S_R_CHECK
   } crr_state_e;
endpackage

// ---- tb/crr_host_model.sv ----
/*
 Host-side partner: drives the control pins, the power state, charge ticks and
 removal/attach events. Assumes the bench calls its tasks; every change lands
 by non-blocking assignment just after a rising edge of core_clk.
*/
`timescale 1ns/1ps
module crr_host_model (
   input wire logic core_clk,
   output logic mode_pin_a,
   output logic mode_pin_b,
   output logic emulation_allow_pin,
   output logic bypass_select_pin,
   output logic port_switch_enable_pin,
   output logic power_active,
   output logic charge_tick,
   output logic [7:0] charge_amount,
   output logic removal_evt,
   output logic attach_evt
);
   logic [4:0] pins_ff = 5'h00;
   assign {mode_pin_a, mode_pin_b, emulation_allow_pin, bypass_select_pin,
      port_switch_enable_pin} = pins_ff;
   initial begin
      power_active = 1'b0;
      charge_tick = 1'b0;
      charge_amount = 8'h00;
      removal_evt = 1'b0;
      attach_evt = 1'b0;
   end
   task automatic set_pins(input logic [4:0] p);
      @(posedge core_clk);
      pins_ff <= p;
   endtask
   task automatic set_power(input logic a);
      @(posedge core_clk);
      power_active <= a;
   endtask
   // amount is scrambled outside the tick so a design that ignores the strobe is caught
   task automatic tick(input logic [7:0] a);
      @(posedge core_clk);
      charge_tick <= 1'b1;
      charge_amount <= a;
      @(posedge core_clk);
      charge_tick <= 1'b0;
      charge_amount <= ~a;
   endtask
   task automatic replug();
      @(posedge core_clk);
      removal_evt <= 1'b1;
      @(posedge core_clk);
      removal_evt <= 1'b0;
      attach_evt <= 1'b1;
      @(posedge core_clk);
      attach_evt <= 1'b0;
   endtask
endmodule

// ---- tb/crr_ctrl_tb_top.sv ----
/*
 Self-checking bench for the rationing controller: register master, read-data
 queue with a watching process, pulse counters and rationing scenarios.
 Assumes the host model drives every pin-side input of the controller.
*/
`timescale 1ns/1ps
module crr_ctrl_tb_top;
   import crr_pkg::*;
   logic core_clk = 1'b0;
   logic rst_n = 1'b0;
   logic [7:0] reg_addr = 8'h00;
   logic [31:0] reg_wdata = 32'h0;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [31:0] reg_rdata;
   logic pa, pb, pe, ps, pw, act, tk, rm, at;
   logic [7:0] amt;
   logic alert_n, emul_remove, switch_open, sleep_force, power_reselect, emul_restart, irq;
   int n_fail = 0;
   int num_checks = 0;
   int n_rst = 0;
   int n_sel = 0;
   int n0, n1;
   logic rd_seen = 1'b0;
   logic [31:0] exp_q[$];
   logic [31:0] lim, sum;
   logic [7:0] a8;
   logic [4:0] p0, p1;
   logic [1:0] nb[3] = '{2'h1, 2'h2, 2'h0};
   logic [3:0] eo[3] = '{4'h6, 4'hF, 4'h0};
   initial begin
      forever #12.5 core_clk = ~core_clk;
   end
   crr_ctrl crr_ctrl_inst (.core_clk(core_clk), .rst_n(rst_n), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .mode_pin_a(pa), .mode_pin_b(pb), .emulation_allow_pin(pe), .bypass_select_pin(ps),
      .port_switch_enable_pin(pw), .power_active(act), .charge_tick(tk),
      .charge_amount(amt), .removal_evt(rm), .attach_evt(at), .alert_n(alert_n),
      .emul_remove(emul_remove), .switch_open(switch_open), .sleep_force(sleep_force),
      .power_reselect(power_reselect), .emul_restart(emul_restart), .irq(irq));
   crr_host_model crr_host_model_inst (.core_clk(core_clk), .mode_pin_a(pa),
      .mode_pin_b(pb), .emulation_allow_pin(pe), .bypass_select_pin(ps),
      .port_switch_enable_pin(pw), .power_active(act), .charge_tick(tk),
      .charge_amount(amt), .removal_evt(rm), .attach_evt(at));
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      num_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic finish_test();
      $display("checks %0d mismatches %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   // read data stands only in the cycle after the strobe, so it is taken at that edge
   always @(posedge core_clk) begin
      if (rd_seen && exp_q.size() > 0) begin
         chk("reg_rdata", exp_q.pop_front(), reg_rdata);
      end
      rd_seen <= reg_rd;
      if (emul_restart === 1'b1) n_rst++;
      if (power_reselect === 1'b1) n_sel++;
   end
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge core_clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge core_clk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      @(posedge core_clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      exp_q.push_back(e);
      @(posedge core_clk);
      reg_rd <= 1'b0;
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge core_clk);
   endtask
   task automatic outs(input logic [3:0] e);
      chk("forced outputs", {28'h0, e}, {28'h0, alert_n, emul_remove, switch_open,
         sleep_force});
   endtask
   task automatic hit(input logic [1:0] beh);
      lim = 32'($urandom_range(1, 100));
      wr(OFS_LIMIT, lim);
      wr(OFS_CTRL, {28'h0, 2'b10, beh});
      crr_host_model_inst.tick(lim[7:0]);
      cyc(8);
   endtask
   task automatic rrst(input logic [1:0] beh);
      wr(OFS_CTRL, {28'h0, 2'b11, beh});
      cyc(8);
   endtask
   initial begin
      repeat (20000) @(posedge core_clk);
      n_fail++;
      finish_test();
   end
   initial begin
      void'($urandom(37695));
      repeat (20) @(posedge core_clk);
      rst_n <= 1'b1;
      rd(OFS_CTRL, 32'h1);
      rd(OFS_LIMIT, 32'h0);
      rd(OFS_IRQ_MASK, 32'h0);
      rd(8'h18, 32'h0);
      crr_host_model_inst.set_power(1'b1);
      wr(OFS_LIMIT, 32'hC8);
      wr(OFS_CTRL, 32'hB);
      sum = 32'h0;
      for (int i = 0; i < 3; i++) begin
         a8 = 8'($urandom_range(1, 40));
         sum = sum + 32'(a8);
         crr_host_model_inst.tick(a8);
      end
      cyc(2);
      rd(OFS_ACCUM, sum);
      wr(OFS_CTRL, 32'h8);
      cyc(3);
      outs(4'h8);
      rd(OFS_ACCUM, sum);
      n0 = n_rst;
      crr_host_model_inst.replug();
      cyc(3);
      chk("restart pulses", 32'h1, 32'(n_rst - n0));
      rd(OFS_ACCUM, sum);
      crr_host_model_inst.set_power(1'b0);
      crr_host_model_inst.tick(8'h10);
      cyc(2);
      rd(OFS_ACCUM, sum);
      crr_host_model_inst.set_power(1'b1);
      rrst(2'b00);
      rd(OFS_ACCUM, 32'h0);
      wr(OFS_IRQ_STAT, 32'h7);
      wr(OFS_IRQ_MASK, 32'h1);
      hit(2'b00);
      outs(4'h0);
      rd(OFS_STATUS, 32'h3 | (32'(S_HELD) << 5));
      chk("irq", 32'h1, {31'h0, irq});
      wr(OFS_IRQ_STAT, 32'h1);
      cyc(2);
      chk("irq", 32'h0, {31'h0, irq});
      rrst(2'b00);
      outs(4'h8);
      rd(OFS_STATUS, 32'h0);
      p0 = 5'($urandom_range(0, 31));
      crr_host_model_inst.set_pins(p0);
      hit(2'b01);
      outs(4'h6);
      p1 = (p0 ^ 5'h10) | 5'h04;
      crr_host_model_inst.set_pins(p1);
      n0 = n_rst;
      n1 = n_sel;
      rrst(2'b01);
      outs(4'h8);
      chk("reselect pulses", 32'h1, 32'(n_sel - n1));
      chk("restart pulses", 32'h1, 32'(n_rst - n0));
      hit(2'b10);
      outs(4'hF);
      n1 = n_sel;
      crr_host_model_inst.set_pins(p1 ^ 5'h01);
      cyc(4);
      chk("reselect pulses", 32'h0, 32'(n_sel - n1));
      crr_host_model_inst.set_pins(p1);
      n0 = n_rst;
      rrst(2'b10);
      outs(4'h8);
      chk("reselect pulses", 32'h0, 32'(n_sel - n1));
      chk("restart pulses", 32'h0, 32'(n_rst - n0));
      for (int i = 0; i < 3; i++) begin
         hit(2'b11);
         outs(4'h8);
         wr(OFS_CTRL, {28'h0, 2'b10, nb[i]});
         cyc(6);
         outs(eo[i]);
         rrst(nb[i]);
         outs(4'h8);
      end
      cyc(3);
      finish_test();
   end
endmodule
